// ---- src/fec_pkg.sv ----
// package for the 4B/5B and MLT-3 symbol codec: codes, field layout, carriers
// Function
// - each data nibble maps to its fixed 5-bit code-group and back
// - idle is 11111 and decodes to nibble 0000
// - first start symbol is 11000 and decodes to 0101
// - second start symbol is 10001 and decodes to 0101
// - first end symbol is 01101 and decodes to 0000
// - second end symbol is 00111 and decodes to 0000
// - code-group 00100 is halt, an error, never data
// - NRZI stream splits into two streams with alternating one events
// - the line output at 100 Mb/s carries MLT-3 only, no binary mode
// - receive 125 Mb/s serial symbols become synchronous nibbles for the MAC
// - descrambler and 5B/4B decoder each have a bypass
// - with the descrambler active, link pulses or fast link pulses never assert signal detect
// - frame start sends 11000 10001 in place of the first preamble byte
// - on enable drop send 01101 00111, then idles until enable returns
// - start pair after idles becomes 0101 0101; decode until first end symbol 01101 or two idles
package fec_pkg;
  localparam logic [4:0] CG_IDLE = 5'h1F;
  localparam logic [4:0] CG_J    = 5'h18;
  localparam logic [4:0] CG_K    = 5'h11;
  localparam logic [4:0] CG_T    = 5'h0D;
  localparam logic [4:0] CG_R    = 5'h07;
  localparam logic [4:0] CG_HALT = 5'h04;
  localparam logic [3:0] NIB_PRE = 4'h5;
  localparam logic [3:0] NIB_ZERO = 4'h0;
  localparam logic [3:0] NIB_BAD_SSD = 4'hE;
  localparam int         SYM_BITS = 5;
  localparam int         DESCR_LOCK_IDLES = 12;
  localparam logic [10:0] LFSR_SEED = 11'h7FF;
  localparam int         LFSR_TAP_HI = 10;
  localparam int         LFSR_TAP_LO = 8;

  // one decoded symbol as seen by the receive nibble path
  typedef struct packed {
    logic [3:0] nib;
    logic       dv;
    logic       er;
  } fec_rx_nib_s;

  // line driver pair, one leg per side of the transformer
  typedef struct packed {
    logic pos;
    logic neg;
  } fec_line_s;

  // data nibble to code-group
  function automatic logic [4:0] fec_enc(input logic [3:0] n);
    logic [4:0] c;
    c = 5'h1E;
    case (n)
      4'h0: c = 5'h1E;
      4'h1: c = 5'h09;
      4'h2: c = 5'h14;
      4'h3: c = 5'h15;
      4'h4: c = 5'h0A;
      4'h5: c = 5'h0B;
      4'h6: c = 5'h0E;
      4'h7: c = 5'h0F;
      4'h8: c = 5'h12;
      4'h9: c = 5'h13;
      4'hA: c = 5'h16;
      4'hB: c = 5'h17;
      4'hC: c = 5'h1A;
      4'hD: c = 5'h1B;
      4'hE: c = 5'h1C;
      default: c = 5'h1D;
    endcase
    return c;
  endfunction : fec_enc

  // code-group to nibble; bit 4 set means not a data code
  function automatic logic [4:0] fec_dec(input logic [4:0] c);
    logic [4:0] r;
    r = 5'h10;
    case (c)
      5'h1E: r = 5'h00;
      5'h09: r = 5'h01;
      5'h14: r = 5'h02;
      5'h15: r = 5'h03;
      5'h0A: r = 5'h04;
      5'h0B: r = 5'h05;
      5'h0E: r = 5'h06;
      5'h0F: r = 5'h07;
      5'h12: r = 5'h08;
      5'h13: r = 5'h09;
      5'h16: r = 5'h0A;
      5'h17: r = 5'h0B;
      5'h1A: r = 5'h0C;
      5'h1B: r = 5'h0D;
      5'h1C: r = 5'h0E;
      5'h1D: r = 5'h0F;
      default: r = 5'h10;
    endcase
    return r;
  endfunction : fec_dec
endpackage : fec_pkg

// ---- src/fec_codec.sv ----
// 4B/5B symbol codec with NRZI/MLT-3 split on transmit and decode on receive
module fec_codec (
  input  wire logic       CLK_SYS_I,
  input  wire logic       RSTN_I,
  input  wire logic       TX_EN_I,
  input  wire logic [3:0] TXD_I,
  input  wire logic       TX_BYPASS_I,
  input  wire logic [4:0] TX_SYM_I,
  output logic            TX_LINE_PAIR_POS_O,
  output logic            TX_LINE_PAIR_NEG_O,
  output logic            TX_BIT_O,
  input  wire logic       RX_BIT_I,
  input  wire logic       RX_SIG_DET_I,
  input  wire logic       RX_DESCR_BYPASS_I,
  input  wire logic       RX_DEC_BYPASS_I,
  output logic [3:0]      RXD_O,
  output logic            RX_DV_O,
  output logic            RX_ER_O,
  output logic            RX_SYM_ERR_O,
  output logic [4:0]      RX_SYM_O,
  output logic            RX_SYM_VLD_O,
  output logic            RX_DESCR_LOCK_O,
  output logic            SIG_DET_O
);

  typedef enum {TX_IDLE, TX_K, TX_DATA, TX_R} fec_tx_e;
  typedef enum {RX_HUNT, RX_DATA} fec_rx_e;

  // ---------------- transmit ----------------
  fec_tx_e    tx_st;
  fec_tx_e    next_tx_st;
  logic [2:0] tx_bit_cnt;
  logic [4:0] tx_sh;
  logic [10:0] tx_lfsr;
  logic       nrzi;
  logic [1:0] mlt_phase;
  fec_pkg::fec_line_s line;

  wire sym_end   = (tx_bit_cnt == 3'(fec_pkg::SYM_BITS - 1));
  wire tx_fb     = tx_lfsr[fec_pkg::LFSR_TAP_HI] ^ tx_lfsr[fec_pkg::LFSR_TAP_LO];
  wire tx_scr    = tx_sh[4] ^ tx_fb;
  wire tx_one    = tx_scr;

  // symbol chosen at each symbol boundary; the MAC nibble is held per symbol
  logic [4:0] tx_next_sym;
  always_comb
  begin
    next_tx_st  = tx_st;
    tx_next_sym = fec_pkg::CG_IDLE;
    case (tx_st)
      TX_IDLE:
      begin
        if (TX_EN_I)
        begin
          next_tx_st  = TX_K;
          tx_next_sym = fec_pkg::CG_J;
        end
        else
          tx_next_sym = fec_pkg::CG_IDLE;
      end
      TX_K:
      begin
        next_tx_st  = TX_DATA;
        tx_next_sym = fec_pkg::CG_K;
      end
      TX_DATA:
      begin
        if (TX_EN_I)
          tx_next_sym = fec_pkg::fec_enc(TXD_I);
        else
        begin
          next_tx_st  = TX_R;
          tx_next_sym = fec_pkg::CG_T;
        end
      end
      TX_R:
      begin
        next_tx_st  = TX_IDLE;
        tx_next_sym = fec_pkg::CG_R;
      end
      default:
      begin
        next_tx_st  = TX_IDLE;
        tx_next_sym = fec_pkg::CG_IDLE;
      end
    endcase
  end

  // symbol shifter with encoder bypass; msb leaves first
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      tx_st      <= TX_IDLE;
      tx_bit_cnt <= 3'h0;
      tx_sh      <= fec_pkg::CG_IDLE;
    end
    else if (sym_end)
    begin
      tx_st      <= TX_BYPASS_I ? TX_IDLE : next_tx_st;
      tx_bit_cnt <= 3'h0;
      tx_sh      <= TX_BYPASS_I ? TX_SYM_I : tx_next_sym;
    end
    else
    begin
      tx_bit_cnt <= tx_bit_cnt + 3'h1;
      tx_sh      <= {tx_sh[3:0], 1'b0};
    end
  end

  // scrambler, NRZI and the three-level stepper
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      tx_lfsr   <= fec_pkg::LFSR_SEED;
      nrzi      <= 1'b0;
      mlt_phase <= 2'h0;
      line      <= '0;
    end
    else
    begin
      tx_lfsr <= {tx_lfsr[9:0], tx_fb};
      nrzi    <= nrzi ^ tx_scr;
      if (tx_one)
      begin
        mlt_phase <= mlt_phase + 2'h1;
        line.pos  <= (mlt_phase == 2'h0);
        line.neg  <= (mlt_phase == 2'h2);
      end
    end
  end

  // only the MLT-3 pair reaches the line, no binary drive mode exists
  assign TX_LINE_PAIR_POS_O = line.pos;
  assign TX_LINE_PAIR_NEG_O = line.neg;
  assign TX_BIT_O           = nrzi;

  // ---------------- receive ----------------
  logic [10:0] rx_lfsr;
  logic [5:0]  idle_run;
  logic        lock;
  logic        rx_prev;
  logic [9:0]  rx_win;
  logic [2:0]  rx_cnt;
  logic        aligned;
  fec_rx_e     rx_st;
  fec_rx_e     next_rx_st;
  logic        idle_seen;
  fec_pkg::fec_rx_nib_s nib;
  fec_pkg::fec_rx_nib_s next_nib;
  fec_pkg::fec_rx_nib_s nib_hold;
  fec_pkg::fec_rx_nib_s nib_show;
  logic [4:0]  rx_sym;
  logic        rx_sym_vld;

  // nrzi to nrz, then descramble the nrz bit with a key loaded from idles, free-running once locked
  wire rx_nrz   = RX_BIT_I ^ rx_prev;
  wire rx_fb    = rx_lfsr[fec_pkg::LFSR_TAP_HI] ^ rx_lfsr[fec_pkg::LFSR_TAP_LO];
  wire rx_ud    = RX_DESCR_BYPASS_I ? rx_nrz : (rx_nrz ^ rx_fb);
  wire [9:0] rx_win_n = {rx_win[8:0], rx_ud};
  wire jk_hit   = (rx_win_n == {fec_pkg::CG_J, fec_pkg::CG_K});
  wire sym_tick = aligned && (rx_cnt == 3'(fec_pkg::SYM_BITS - 1));
  wire [4:0] cur_sym = rx_win_n[4:0];
  wire [4:0] dec_r   = fec_pkg::fec_dec(cur_sym);
  wire is_data  = !dec_r[4];
  wire is_ctl   = (cur_sym == fec_pkg::CG_IDLE) || (cur_sym == fec_pkg::CG_J) ||
                  (cur_sym == fec_pkg::CG_K) || (cur_sym == fec_pkg::CG_T) ||
                  (cur_sym == fec_pkg::CG_R) || (cur_sym == fec_pkg::CG_HALT);
  wire sym_bad  = !is_data && !is_ctl;
  // a start pair is honoured only between frames; inside one it is just data bits
  wire jk_start = jk_hit && (rx_st != RX_DATA);
  wire rx_upd   = sym_tick || jk_start;
  wire lock_end = (idle_run == 6'(fec_pkg::DESCR_LOCK_IDLES * fec_pkg::SYM_BITS - 1));

  // descrambler lock: the line's signal detect gates the idle count and the lock, and a plain
  // link-pulse burst never produces sustained idle ones so it cannot lock
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      rx_prev  <= 1'b0;
      rx_lfsr  <= fec_pkg::LFSR_SEED;
      idle_run <= 6'h00;
      lock     <= 1'b0;
      rx_win   <= 10'h000;
    end
    else
    begin
      rx_prev <= RX_BIT_I;
      // hunting loads the key assuming idle ones; once locked the key runs free
      rx_lfsr <= {rx_lfsr[9:0], lock ? rx_fb : (rx_nrz ^ 1'b1)};
      rx_win  <= rx_win_n;
      if (!RX_SIG_DET_I || RX_DESCR_BYPASS_I)
      begin
        idle_run <= 6'h00;
        lock     <= 1'b0;
      end
      else if (!lock)
      begin
        // any wrongly predicted bit restarts the run of descrambled idle ones
        idle_run <= rx_ud ? idle_run + 6'h01 : 6'h00;
        if (rx_ud && lock_end)
          lock <= 1'b1;
      end
    end
  end

  // unless the descrambler is bypassed, only a lock gained from scrambled idles counts as signal, not link pulses
  assign SIG_DET_O       = RX_SIG_DET_I && (lock || RX_DESCR_BYPASS_I);
  assign RX_DESCR_LOCK_O = lock;

  // code-group alignment on the J/K pair
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      aligned <= 1'b0;
      rx_cnt  <= 3'h0;
    end
    else if (!SIG_DET_O)
    begin
      aligned <= 1'b0;
      rx_cnt  <= 3'h0;
    end
    else if (jk_start)
    begin
      aligned <= 1'b1;
      rx_cnt  <= 3'h0;
    end
    else
      rx_cnt <= (rx_cnt == 3'(fec_pkg::SYM_BITS - 1)) ? 3'h0 : rx_cnt + 3'h1;
  end

  // decode state and nibble selection
  always_comb
  begin
    next_rx_st = rx_st;
    next_nib   = '{nib: fec_pkg::NIB_ZERO, dv: 1'b0, er: 1'b0};
    case (rx_st)
      RX_HUNT:
      begin
        if (jk_hit)
        begin
          next_rx_st = RX_DATA;
          next_nib   = '{nib: fec_pkg::NIB_PRE, dv: 1'b1, er: 1'b0};
        end
      end
      RX_DATA:
      begin
        if (cur_sym == fec_pkg::CG_T || (cur_sym == fec_pkg::CG_IDLE && idle_seen))
          next_rx_st = RX_HUNT;
        else if (cur_sym == fec_pkg::CG_IDLE)
          next_nib = '{nib: fec_pkg::NIB_ZERO, dv: 1'b1, er: 1'b0};
        else if (cur_sym == fec_pkg::CG_HALT || sym_bad)
          next_nib = '{nib: fec_pkg::NIB_ZERO, dv: 1'b1, er: 1'b1};
        else if (cur_sym == fec_pkg::CG_J || cur_sym == fec_pkg::CG_K)
          next_nib = '{nib: fec_pkg::NIB_PRE, dv: 1'b1, er: 1'b0};
        else if (cur_sym == fec_pkg::CG_R)
          next_nib = '{nib: fec_pkg::NIB_ZERO, dv: 1'b0, er: 1'b0};
        else
          next_nib = '{nib: dec_r[3:0], dv: 1'b1, er: 1'b0};
      end
      default:
        next_rx_st = RX_HUNT;
    endcase
  end

  // the start pair is seen only once K is in, so the output runs one symbol late
  assign nib_show = jk_start ? next_nib : nib_hold;

  // nibble output registers; the held start nibble gives the second preamble nibble
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      rx_st      <= RX_HUNT;
      nib        <= '0;
      nib_hold   <= '0;
      idle_seen  <= 1'b0;
      rx_sym     <= fec_pkg::CG_IDLE;
      rx_sym_vld <= 1'b0;
    end
    else if (!SIG_DET_O)
    begin
      rx_st      <= RX_HUNT;
      nib        <= '0;
      nib_hold   <= '0;
      idle_seen  <= 1'b0;
      rx_sym_vld <= 1'b0;
    end
    else
    begin
      rx_sym_vld <= rx_upd;
      if (rx_upd)
      begin
        rx_sym    <= cur_sym;
        rx_st     <= RX_DEC_BYPASS_I ? RX_HUNT : next_rx_st;
        nib       <= RX_DEC_BYPASS_I ? '0 : nib_show;
        nib_hold  <= RX_DEC_BYPASS_I ? '0 : next_nib;
        idle_seen <= (cur_sym == fec_pkg::CG_IDLE);
      end
    end
  end

  assign RXD_O        = nib.nib;
  assign RX_DV_O      = nib.dv;
  assign RX_ER_O      = nib.er;
  assign RX_SYM_ERR_O = nib.er;
  assign RX_SYM_O     = rx_sym;
  assign RX_SYM_VLD_O = rx_sym_vld;
endmodule : fec_codec

// ---- sim/fec_codec_monitor.sv ----
// checker for the codec's line legs and receive outputs
module fec_codec_monitor (
  input wire logic       CLK_SYS_I,
  input wire logic       RSTN_I,
  input wire logic       TX_LINE_PAIR_POS_O,
  input wire logic       TX_LINE_PAIR_NEG_O,
  input wire logic       RX_SIG_DET_I,
  input wire logic       RX_DESCR_BYPASS_I,
  input wire logic       RX_DEC_BYPASS_I,
  input wire logic [3:0] RXD_O,
  input wire logic       RX_DV_O,
  input wire logic       RX_ER_O,
  input wire logic       RX_SYM_ERR_O,
  input wire logic       RX_SYM_VLD_O,
  input wire logic       RX_DESCR_LOCK_O,
  input wire logic       SIG_DET_O
);
  timeunit 1ns;
  timeprecision 1ns;
  logic seen;
  logic last_pos;
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RSTN_I);

  // last excursion leg; the first one after reset may go either way
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      seen <= 1'h0;
      last_pos <= 1'h0;
    end
    else if (TX_LINE_PAIR_POS_O || TX_LINE_PAIR_NEG_O)
    begin
      seen <= 1'h1;
      last_pos <= TX_LINE_PAIR_POS_O;
    end
  end

  legs_exclusive_a: assert property (!(TX_LINE_PAIR_POS_O && TX_LINE_PAIR_NEG_O))
    else $error("both line legs high");
  pos_via_zero_a: assert property ($rose(TX_LINE_PAIR_POS_O) |-> !$past(TX_LINE_PAIR_NEG_O))
    else $error("line jumped from minus to plus");
  leg_alternate_a: assert property ($rose(TX_LINE_PAIR_POS_O) && seen |-> !last_pos)
    else $error("plus leg used twice in a row");
  neg_alternate_a: assert property ($rose(TX_LINE_PAIR_NEG_O) && seen |-> last_pos)
    else $error("minus leg used twice in a row");
  sym_err_same_a: assert property (RX_SYM_ERR_O == RX_ER_O)
    else $error("symbol error differs from rx error");
  vld_pulse_a: assert property (RX_SYM_VLD_O |=> !RX_SYM_VLD_O)
    else $error("symbol strobe longer than one cycle");
  sd_qualify_a: assert property (!RX_SIG_DET_I |-> !SIG_DET_O)
    else $error("signal detect without analog detect");
  sd_lock_a: assert property (!RX_DESCR_BYPASS_I && !RX_DESCR_LOCK_O |-> !SIG_DET_O)
    else $error("signal detect before descrambler lock");
  dec_bypass_a: assert property (RX_DEC_BYPASS_I [*6] |-> !RX_DV_O)
    else $error("valid nibbles while decoder bypassed");
  first_pre_a: assert property (RX_DV_O && !$past(RX_DV_O) |-> RXD_O == fec_pkg::NIB_PRE)
    else $error("frame does not open with preamble");
endmodule : fec_codec_monitor

// ---- sim/fec_line_model.sv ----
// far-end model: sends queued code-groups msb first as NRZI, idles between
module fec_line_model (
  input  wire logic clk_i,
  output logic      rx_bit_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] q[$];
  logic [4:0] cur = 5'h1F;
  int         idx = 4;
  initial rx_bit_o = 1'h0;

  task put(input logic [4:0] c);
    q.push_back(c);
  endtask : put

  // idles fill every gap so the receiver never sees a dead line
  always @(posedge clk_i)
  begin
    #1;
    rx_bit_o = rx_bit_o ^ cur[idx];
    if (idx == 0)
    begin
      idx = 4;
      cur = (q.size() > 0) ? q.pop_front() : 5'h1F;
    end
    else
      idx = idx - 1;
  end
endmodule : fec_line_model

// ---- sim/fec_codec_tb.sv ----
// self-checking bench for the symbol codec
`define CHK(nm, e, a) begin num_checks++; if ((a) !== (e)) begin n_errors++; \
  $display("[ERR] %s exp %h got %h", nm, e, a); end end
module fec_codec_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 1'h0, rstn = 1'h0, tx_en = 1'h0, tx_byp = 1'h0, loop = 1'h0;
  logic       sd = 1'h1, dscr_byp = 1'h0, dec_byp = 1'h0, hit, sp = 1'h0, sn = 1'h0;
  logic [3:0] txd = 4'h0, rxd;
  logic [4:0] tx_sym = 5'h04, sym;
  logic       rx_bit, pos, neg, txb, dv, er, serr, vld, lock, sdo;
  int         n_errors = 0, num_checks = 0;
  logic [6:0] got[$];
  logic [4:0] s[$];
  logic [8:0] rows[16] = '{9'h1E0, 9'h091, 9'h142, 9'h153, 9'h0A4, 9'h0B5, 9'h0E6, 9'h0F7,
                           9'h128, 9'h139, 9'h16A, 9'h17B, 9'h1AC, 9'h1BD, 9'h1CE, 9'h1DF};
  logic [4:0] bad[11] = '{5'h04, 5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08, 5'h0C,
                          5'h10, 5'h19};

  fec_codec dut (.CLK_SYS_I(clk), .RSTN_I(rstn), .TX_EN_I(tx_en), .TXD_I(txd),
    .TX_BYPASS_I(tx_byp), .TX_SYM_I(tx_sym), .TX_LINE_PAIR_POS_O(pos),
    .TX_LINE_PAIR_NEG_O(neg), .TX_BIT_O(txb), .RX_BIT_I(loop ? txb : rx_bit),
    .RX_SIG_DET_I(sd),
    .RX_DESCR_BYPASS_I(dscr_byp), .RX_DEC_BYPASS_I(dec_byp), .RXD_O(rxd), .RX_DV_O(dv),
    .RX_ER_O(er), .RX_SYM_ERR_O(serr), .RX_SYM_O(sym), .RX_SYM_VLD_O(vld),
    .RX_DESCR_LOCK_O(lock), .SIG_DET_O(sdo));
  fec_line_model line (.clk_i(clk), .rx_bit_o(rx_bit));

  always #50 clk = ~clk;
  // fresh nibble every cycle; the encoder only takes one per symbol boundary
  always @(posedge clk)
  begin
    txd <= #1 txd + 4'h1;
    sp <= sp | pos;
    sn <= sn | neg;
  end

  task report_and_stop;
    if (n_errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  // leading idles make the start pair a legal frame opening
  task frame(input logic [4:0] b[$]);
    repeat (3) line.put(5'h1F);
    line.put(fec_pkg::CG_J);
    line.put(fec_pkg::CG_K);
    foreach (b[i]) line.put(b[i]);
  endtask : frame

  // samples mid-symbol so the once-per-symbol update never races the read
  task grab(input int n);
    int k;
    got.delete();
    k = 0;
    while (dv !== 1'h1 && k < 400)
    begin
      cyc(1);
      k++;
    end
    if (k == 400)
    begin
      n_errors++;
      report_and_stop();
    end
    cyc(2);
    repeat (n)
    begin
      got.push_back({serr, er, dv, rxd});
      cyc(5);
    end
  endtask : grab

  initial
  begin
    cyc(6);
    `CHK("legs rst", 2'h0, {pos, neg})
    `CHK("sym rst", 5'h1F, sym)
    rstn = 1'h1;
    cyc(2);
    `CHK("sd unlocked", 1'h0, sdo)
    dscr_byp = 1'h1;
    tx_en = 1'h1;
    cyc(1);
    `CHK("sd byp", 1'h1, sdo)
    foreach (rows[i]) s.push_back(rows[i][8:4]);
    s.push_back(fec_pkg::CG_T);
    s.push_back(fec_pkg::CG_R);
    frame(s);
    grab(18);
    `CHK("pre0", 7'h15, got[0])
    `CHK("pre1", 7'h15, got[1])
    foreach (rows[i]) `CHK("nib", {3'h1, rows[i][3:0]}, got[i + 2])
    tx_en = 1'h0;
    cyc(30);
    `CHK("after end", 5'h00, {dv, rxd})
    foreach (bad[i])
    begin
      s = {5'h1E, bad[i], 5'h1E, fec_pkg::CG_T, fec_pkg::CG_R};
      frame(s);
      grab(4);
      `CHK("data", 7'h10, got[2])
      `CHK("bad er", 7'h70, got[3])
      cyc(40);
    end
    tx_byp = 1'h1;
    s = {5'h09, 5'h1F, 5'h1F};
    frame(s);
    grab(3);
    `CHK("short", 7'h11, got[2])
    cyc(15);
    `CHK("idle end", 5'h00, {dv, rxd})
    tx_byp = 1'h0;
    dec_byp = 1'h1;
    s = {5'h14, fec_pkg::CG_T, fec_pkg::CG_R};
    frame(s);
    hit = 1'h0;
    repeat (150)
    begin
      cyc(1);
      if (vld === 1'h1 && sym === fec_pkg::CG_K) hit = 1'h1;
    end
    `CHK("raw k", 1'h1, hit)
    `CHK("dv byp", 1'h0, dv)
    dec_byp = 1'h0;
    sd = 1'h0;
    cyc(1);
    `CHK("sd low", 1'h0, sdo)
    sd = 1'h1;
    `CHK("both legs", 2'h3, {sp, sn})
    rstn = 1'h0;
    dscr_byp = 1'h0;
    loop = 1'h1;
    cyc(2);
    `CHK("legs rst2", 3'h0, {pos, neg, txb})
    rstn = 1'h1;
    // own line looped back: scrambled idles must lock the descrambler
    cyc(150);
    `CHK("lock loop", 2'h3, {lock, sdo})
    tx_en = 1'h1;
    grab(4);
    `CHK("loop pre0", 7'h15, got[0])
    `CHK("loop pre1", 7'h15, got[1])
    `CHK("loop data", 3'h1, got[2][6:4])
    // the bench nibble steps once a cycle and the encoder takes one per 5 cycles
    `CHK("loop step", 4'(got[2][3:0] + 4'h5), got[3][3:0])
    tx_en = 1'h0;
    cyc(40);
    `CHK("loop end", 5'h00, {dv, rxd})
    `CHK("loop idle", fec_pkg::CG_IDLE, sym)
    report_and_stop();
  end
endmodule : fec_codec_tb

bind fec_codec fec_codec_monitor u_mon (.CLK_SYS_I(CLK_SYS_I), .RSTN_I(RSTN_I),
  .TX_LINE_PAIR_POS_O(TX_LINE_PAIR_POS_O), .TX_LINE_PAIR_NEG_O(TX_LINE_PAIR_NEG_O),
  .RX_SIG_DET_I(RX_SIG_DET_I), .RX_DESCR_BYPASS_I(RX_DESCR_BYPASS_I),
  .RX_DEC_BYPASS_I(RX_DEC_BYPASS_I), .RXD_O(RXD_O), .RX_DV_O(RX_DV_O), .RX_ER_O(RX_ER_O),
  .RX_SYM_ERR_O(RX_SYM_ERR_O), .RX_SYM_VLD_O(RX_SYM_VLD_O),
  .RX_DESCR_LOCK_O(RX_DESCR_LOCK_O), .SIG_DET_O(SIG_DET_O));
